// [hdl/analog_switch_scan_sequencer.sv]
`timescale 1ns/1ps
`default_nettype none
module analog_switch_scan_sequencer
  import scan_seq_pkg::*;
#(
  parameter int unsigned NSW   = NUM_SWITCHES,
  parameter int unsigned DELAY = CHAIN_DELAY
)
(
  input  wire logic           clk,
  input  wire logic           reset_n,
  input  wire logic           scan_start_in,
  output var  logic           scan_start_out,
  output var  logic [NSW-1:0] switch_closed,
  output var  logic           slot_advance_pulse,
  output var  logic           scan_active
);
  logic              tick;
  logic              sync1_ff;
  logic              sync2_ff;
  logic              sync3_ff;
  logic              start;
  scan_state_t       state_ff;
  scan_state_t       nxt_state;
  logic [SUB_W-1:0]  sub_ff;
  logic [SUB_W-1:0]  nxt_sub;
  logic [SLOT_W-1:0] slot_ff;
  logic [SLOT_W-1:0] nxt_slot;
  logic [DLY_W-1:0]  dly_ff;
  logic [DLY_W-1:0]  nxt_dly;
  logic              dly_run_ff;
  logic              nxt_dly_run;
  logic              wrap;
  logic              scanning;
  logic              last_slot;
  logic              close_window;
  logic              dly_done;
  logic [NSW-1:0]    nxt_switch;

  // Master tick enable; the 100 kHz rate is made here
  tick_divider #(.DIV(TICK_DIV)) u_div
  (
    .clk     (clk),
    .reset_n (reset_n),
    .tick    (tick)
  );

  // Pin input passes two flops before the edge detector reads it
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      sync3_ff <= 1'b0;
    end
    else
    begin
      sync1_ff <= scan_start_in;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  // Decodes shared by the counters and the switch drive
  assign start        = sync2_ff & ~sync3_ff;
  assign scanning     = state_ff == ST_SCAN;
  assign wrap         = tick && (sub_ff == SUB_W'(SUBSLOT_MOD - 1));
  assign last_slot    = slot_ff == SLOT_W'(NSW - 1);
  assign close_window = sub_ff <= SUB_W'(CLOSED_LAST);
  assign dly_done     = dly_run_ff && tick && dly_ff == DLY_W'(DELAY - 1);

  // Next scan state; a new start restarts even mid-scan
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: nxt_state = ST_IDLE;
      ST_SCAN:
        if (wrap && last_slot)
          nxt_state = ST_DONE;
      ST_DONE: nxt_state = ST_DONE;
      default: nxt_state = ST_IDLE;
    endcase
    if (start)
      nxt_state = ST_SCAN;
  end

  // Scan state register
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      state_ff <= ST_IDLE;
    else
      state_ff <= nxt_state;
  end

  // Sub-slot next value, modulo ten on master ticks
  always_comb
  begin
    nxt_sub = sub_ff;
    if (start)
      nxt_sub = '0;
    else if (scanning && tick)
      nxt_sub = wrap ? '0 : sub_ff + 1'b1;
  end

  // Sub-slot counter register
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      sub_ff <= '0;
    else
      sub_ff <= nxt_sub;
  end

  // Slot holds on the last value so the decode never aliases a switch
  always_comb
  begin
    nxt_slot = slot_ff;
    if (start)
      nxt_slot = '0;
    else if (scanning && wrap && !last_slot)
      nxt_slot = slot_ff + 1'b1;
  end

  // Slot counter register
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      slot_ff <= '0;
    else
      slot_ff <= nxt_slot;
  end

  // Wrap pulse brought out, one cycle long
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      slot_advance_pulse <= 1'b0;
    else
      slot_advance_pulse <= state_ff == ST_SCAN && wrap && !start;
  end

  // One-hot slot decode; only one bit can ever be set
  // Direction is set by the analog side, so mux and demux share it
  generate
    for (genvar i = 0; i < NSW; i++)
    begin : g_sw
      assign nxt_switch[i] = scanning && !start
                             && slot_ff == SLOT_W'(i)
                             && close_window;
    end
  endgenerate

  // Switch drive register; a start opens all for one cycle
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      switch_closed <= '0;
    else
      switch_closed <= nxt_switch;
  end

  // Scan busy flag for the outside
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      scan_active <= 1'b0;
    else
      scan_active <= state_ff == ST_SCAN;
  end

  // Chain delay next values, counted in master ticks from the start edge
  always_comb
  begin
    nxt_dly     = dly_ff;
    nxt_dly_run = dly_run_ff;
    if (start)
    begin
      nxt_dly     = '0;
      nxt_dly_run = 1'b1;
    end
    else if (dly_run_ff && tick)
    begin
      nxt_dly     = dly_ff + 1'b1;
      nxt_dly_run = !dly_done;
    end
  end

  // Chain delay register
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      dly_ff     <= '0;
      dly_run_ff <= 1'b0;
    end
    else
    begin
      dly_ff     <= nxt_dly;
      dly_run_ff <= nxt_dly_run;
    end
  end

  // Rises on the 100th tick, falls when the input has fallen
  always_ff @(posedge clk)
  begin
    if (!reset_n || !sync2_ff)
      scan_start_out <= 1'b0;
    else if (dly_done)
      scan_start_out <= 1'b1;
  end
endmodule
`default_nettype wire

// [hdl/scan_seq_pkg.sv]
package scan_seq_pkg;
  // Master tick rate and system clock
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned TICK_HZ         = 100_000;
  localparam int unsigned TICK_DIV        = CLK_HZ / TICK_HZ;
  // Scan geometry
  localparam int unsigned NUM_SWITCHES    = 10;
  localparam int unsigned SUBSLOT_MOD     = 10;
  localparam int unsigned CLOSED_LAST     = 7;
  localparam int unsigned CHAIN_DELAY     = 100;
  localparam int unsigned SUB_W           = 4;
  localparam int unsigned SLOT_W          = 4;
  localparam int unsigned DLY_W           = 7;
  localparam int unsigned DIV_W           = 8;

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b001,
    ST_SCAN = 3'b010,
    ST_DONE = 3'b100
  } scan_state_t;
endpackage

// [hdl/tick_divider.sv]
`timescale 1ns/1ps
`default_nettype none
// Turns the system clock into the one-cycle master tick enable
module tick_divider
  import scan_seq_pkg::*;
#(
  parameter int unsigned DIV = TICK_DIV
)
(
  input  wire logic clk,
  input  wire logic reset_n,
  output var  logic tick
);
  logic [DIV_W-1:0] cnt_ff;

  // Free-running divider, tick on terminal count
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      cnt_ff <= '0;
      tick   <= 1'b0;
    end
    else if (cnt_ff == DIV_W'(DIV - 1))
    begin
      cnt_ff <= '0;
      tick   <= 1'b1;
    end
    else
    begin
      cnt_ff <= cnt_ff + 1'b1;
      tick   <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// [verif/analog_switch_scan_sequencer_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module analog_switch_scan_sequencer_tb;
  import scan_seq_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic go = 1'b0;
  logic scan_start_in, scan_start_out, slot_advance_pulse, scan_active;
  logic [NUM_SWITCHES-1:0] switch_closed;
  int err_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  int pulses = 0;
  // Clock and a cycle count for timing
  always #25 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  // Wrap pulses counted away from the edge that launches them
  always @(negedge clk)
    if (slot_advance_pulse === 1'b1)
      pulses <= pulses + 1;
  scan_ctrl_model ctrl (.clk(clk), .go(go), .scan_start_in(scan_start_in));
  analog_switch_scan_sequencer uut
  (
    .clk(clk), .reset_n(reset_n), .scan_start_in(scan_start_in),
    .scan_start_out(scan_start_out), .switch_closed(switch_closed),
    .slot_advance_pulse(slot_advance_pulse), .scan_active(scan_active)
  );
  task automatic tally_and_finish;
    $display("%0d checks, %0d mismatches", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: saw %0h want %0h", $time, seen, exp);
    end
  endtask
  // Bounded wait on switches or chain out; a hang ends the run
  task automatic waitv(input bit o, input logic [9:0] v);
    int n;
    for (n = 0; (o ? {9'h0, scan_start_out} : switch_closed) !== v; n++)
    begin
      if (n == 3000)
      begin
        err_count++;
        tally_and_finish;
      end
      @(posedge clk);
      #1;
    end
  endtask
  // First slot may be short: the tick phase is free against start
  task automatic scan_test;
    int k, ts, t0, tp, p0;
    p0 = pulses;
    go = 1'b1;
    ts = cyc;
    for (k = 0; k < NUM_SWITCHES; k++)
    begin
      waitv(0, 10'h001 << k);
      t0 = cyc;
      chk(k > 0 || (t0 - ts) inside {[3:7]}, 1);
      chk(k < 2 || t0 - tp == 2000, 1);
      waitv(0, '0);
      chk(k == 0 || cyc - t0 == 1600, 1);
      tp = t0;
    end
    waitv(1, 1);
    chk((cyc - tp) inside {[1999:2001]}, 1);
    repeat (4) @(posedge clk);
    #1;
    chk({scan_active, switch_closed}, 0);
    chk(pulses - p0, 10);
    go = 1'b0;
    t0 = cyc;
    waitv(1, 0);
    chk(cyc - t0 < 7, 1);
    $display("scan test done");
  endtask
  // Reset, then two scans back to back
  initial
  begin
    repeat (12) @(posedge clk);
    #1 reset_n = 1'b1;
    repeat (2) scan_test;
    tally_and_finish;
  end
endmodule
`default_nettype wire

// [verif/scan_ctrl_model.sv]
`timescale 1ns/1ps
`default_nettype none
module scan_ctrl_model
(
  input  wire logic clk,
  input  wire logic go,
  output var  logic scan_start_in
);
  // Start launched just after an edge, as a clocked controller would
  initial
  begin
    scan_start_in = 1'b0;
    forever
      @(posedge clk) scan_start_in <= #1 go;
  end
endmodule
`default_nettype wire

// [verif/scan_seq_checker_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module scan_seq_checker
#(
  parameter int unsigned NSW = 10
)
(
  input wire logic           clk,
  input wire logic           reset_n,
  input wire logic           scan_start_in,
  input wire logic           scan_start_out,
  input wire logic [NSW-1:0] switch_closed,
  input wire logic           slot_advance_pulse,
  input wire logic           scan_active
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Gaps last two ticks, far longer than eight clocks
  sequence all_open_s;
    !(|switch_closed) [*8];
  endsequence
  // Switch and chain timing
  one_hot_a: assert property ($onehot0(switch_closed))
    else $error("two switches closed");
  idle_open_a: assert property (!scan_active |-> !(|switch_closed))
    else $error("switch closed while idle");
  pulse_one_a: assert property (slot_advance_pulse |=>
    (!slot_advance_pulse) [*8]) else $error("pulse too long");
  start_close_a: assert property ($rose(scan_start_in) |->
    ##[2:6] (switch_closed[0] && scan_active)) else $error("no start");
  close_hold_a: assert property ($rose(|switch_closed) |->
    (|switch_closed) [*8]) else $error("close too short");
  open_gap_a: assert property ($fell(|switch_closed) |-> all_open_s)
    else $error("gap too short");
  slot_next_a: assert property ($fell(switch_closed[0]) |->
    ##[399:401] switch_closed[1]) else $error("slot order");
  out_follow_a: assert property (scan_start_out |->
    $past(scan_start_in, 5)) else $error("out without in");
endmodule
bind analog_switch_scan_sequencer scan_seq_checker #(.NSW(NSW)) chk_i
(
  .clk(clk), .reset_n(reset_n), .scan_start_in(scan_start_in),
  .scan_start_out(scan_start_out), .switch_closed(switch_closed),
  .slot_advance_pulse(slot_advance_pulse), .scan_active(scan_active)
);
`default_nettype wire
